// File: logic/byte_fifo.sv
// Byte FIFO with registered read data
`timescale 1ns/100ps
module byte_fifo
   import radio_dp_pkg::*;
#(
   parameter int DEPTH = FIFO_DEPTH,
   parameter int AW    = $clog2(DEPTH)
) (
   // Clock and reset
   input  wire logic       mclk,
   input  wire logic       resetn,
   input  wire logic       flush,
   // Write side
   input  wire logic       wrValid,
   input  wire logic [7:0] wrData,
   // Read side
   input  wire logic       rdReq,
   output      logic [7:0] rdData,
   output      logic       empty,
   output      logic       full
);
   logic [7:0]  mem [DEPTH];
   logic [AW:0] count;
   logic [AW-1:0] wrPtr;
   logic [AW-1:0] rdPtr;
   logic doWr;
   logic doRd;

   assign empty = (count == '0);
   assign full  = (count == (AW+1)'(DEPTH));
   assign doRd  = rdReq && !empty;
   assign doWr  = wrValid && (!full || doRd);

   always_ff @(posedge mclk) begin
      if (doWr) begin
         mem[wrPtr] <= wrData;
      end
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         wrPtr <= '0;
         rdPtr <= '0;
         count <= '0;
         rdData <= 8'h00;
      end else if (flush) begin
         wrPtr <= '0;
         rdPtr <= '0;
         count <= '0;
      end else begin
         if (doWr) begin
            wrPtr <= (wrPtr == AW'(DEPTH-1)) ? '0 : wrPtr + 1'b1;
         end
         if (doRd) begin
            rdData <= mem[rdPtr];
            rdPtr <= (rdPtr == AW'(DEPTH-1)) ? '0 : rdPtr + 1'b1;
         end
         count <= count + (AW+1)'(doWr) - (AW+1)'(doRd);
      end
   end
endmodule

// File: logic/radio_datapath.sv
// Continuous and buffered data path of the radio transceiver
// What this block and its host do
// [RL1] Continuous mode: data pin only, FIFO idle
// [RL2] Continuous transmit drives bit clock on event1
// [RL3] Transmit data sampled on bit clock rising
// [RL4] Host times FSK bits with bit clock
// [RL5] No bit sync: raw data, no clock
// [RL6] Bit sync: clean data, recovered clock
// [RL7] Host should enable bit synchronizer always
// [RL8] Event0 source: 00 sync, 01 RSSI
// [RL9] Continuous standby: no events on pins
// [RL10] Buffered mode: bytes only through FIFO
// [RL11] Buffered forces bit sync; host sets sync
// [RL12] Host writes all transmit bytes to FIFO
// [RL13] Launch on FIFO not empty or full
// [RL14] Transmit without length limit while bytes remain
// [RL15] Last byte to shift stage: not-empty low
// [RL16] Transmit finished when shift stage drained
// [RL17] Leaving transmit stops at once, drops data; on a return to standby the code keeps the FIFO bytes until a flush
// [RL18] Receive fill starts on sync or fill_enable
// [RL19] Keep filling while fill_enable stays set
// [RL20] Host counts bytes and drains FIFO itself
// [RL21] Full FIFO still readable during receive
// [RL22] Overrun when shift stage also fills
// [RL23] Launch condition 1 means start on first byte
// [RL24] Shift stage works most significant bit first
// [RL25] Writing 1 clears overrun and empties FIFO
`timescale 1ns/100ps
module radio_datapath
   import radio_dp_pkg::*;
#(
   parameter int BIT_CNT = BIT_CYCLES
) (
   // Clock and reset
   input  wire logic       mclk,
   input  wire logic       resetn,
   // Control and status
   input  wire ctrl_t      ctrl,
   input  wire logic       fillEnable,
   input  wire logic       overrunClear,
   output      status_t    status,
   // Host byte port
   input  wire logic       queuePortSelectN,
   input  wire logic       hostWrite,
   input  wire logic [7:0] hostWrData,
   output      logic [7:0] hostRdData,
   // Data pin
   input  wire logic       dataIn,
   output      logic       dataOut,
   output      logic       dataOe,
   // Event pins
   output      logic       event0,
   output      logic       bitClockOut,
   // Modem side
   input  wire logic       demodRaw,
   input  wire logic       demodClean,
   input  wire logic       recClock,
   input  wire logic       syncMatch,
   input  wire logic       rssiEvent,
   output      logic       modData
);
   logic [1:0] selSync;
   logic [1:0] dinSync;
   logic       selPrev;
   logic       selRise;
   logic       selFall;
   logic       isCont;
   logic       isBuf;
   logic       inTx;
   logic       inRx;
   logic       bitSync;
   logic [$clog2(BIT_CNT+1)-1:0] bitCnt;
   logic       bitTick;
   logic       halfTick;
   logic       bitPhase;
   logic       txData;
   logic [7:0] shiftStage;
   logic [3:0] shiftBits;
   logic       txActive;
   logic       launched;
   logic       fifoRd;
   logic       fifoRdPend;
   logic       fifoWr;
   logic [7:0] fifoWrData;
   logic       fifoEmpty;
   logic       fifoFull;
   logic       fifoFlush;
   logic       filling;
   logic       rxBit;
   logic       srFull;
   logic       overrun;
   logic       txDone;
   opState_t   prevState;

   assign isCont  = (ctrl.dataMode == MODE_CONTINUOUS);
   assign isBuf   = (ctrl.dataMode == MODE_BUFFERED);
   assign inTx    = (ctrl.opState == OP_TX);
   assign inRx    = (ctrl.opState == OP_RX);
   assign bitSync = ctrl.bitSyncEnable || isBuf; // [RL11]

   // Pin synchronisers
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         selSync <= 2'h3;
         dinSync <= 2'h0;
         selPrev <= 1'h1;
      end else begin
         selSync <= {selSync[0], queuePortSelectN};
         dinSync <= {dinSync[0], dataIn};
         selPrev <= selSync[1];
      end
   end
   assign selFall = selPrev && !selSync[1];
   assign selRise = !selPrev && selSync[1];

   // Bit timing: a full period per tick, clock high in first half
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         bitCnt <= '0;
         bitPhase <= 1'h0;
      end else if (!inTx && !inRx) begin
         bitCnt <= '0;
         bitPhase <= 1'h0;
      end else if (bitTick || fifoRdPend) begin
         // A freshly loaded byte restarts the timer so its first bit lasts a full period
         bitCnt <= '0; // [RL16]
         bitPhase <= 1'h1;
      end else begin
         bitCnt <= bitCnt + 1'b1;
         if (halfTick) begin
            bitPhase <= 1'h0;
         end
      end
   end
   assign bitTick  = (bitCnt == ($clog2(BIT_CNT+1))'(BIT_CNT-1));
   assign halfTick = (bitCnt == ($clog2(BIT_CNT+1))'(BIT_CNT/2-1));

   // Continuous transmit: sample host data at the rising bit clock
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         txData <= 1'h0;
      end else if (isCont && inTx && bitTick) begin
         txData <= dinSync[1]; // [RL3]
      end
   end

   // Host byte port: write on select rise, read on select fall
   assign fifoRd     = (isBuf && selFall && !hostWrite) || (isBuf && inTx && bitTick && txActive
                       && shiftBits == 4'h1)
                       || (isBuf && inTx && !txActive && !fifoRdPend && launched && !fifoEmpty); // [RL10] [RL14]
   assign fifoFlush  = overrunClear || (ctrl.opState != prevState && ctrl.opState != OP_STANDBY); // [RL25]

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         prevState <= OP_STANDBY;
      end else begin
         prevState <= ctrl.opState;
      end
   end

   // Launch condition
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         launched <= 1'h0;
      end else if (!inTx || !isBuf) begin
         launched <= 1'h0;
      end else if (ctrl.txLaunchCondition == LAUNCH_NOTEMPTY ? !fifoEmpty : fifoFull) begin
         launched <= 1'h1; // [RL13] [RL23]
      end
   end

   // Byte taken from FIFO lands one cycle later
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         fifoRdPend <= 1'h0;
      end else begin
         fifoRdPend <= fifoRd && !fifoEmpty && isBuf && inTx && !(selFall && !hostWrite);
      end
   end

   // Shift stage for transmit and receive
   assign rxBit = bitSync ? demodClean : demodRaw;
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         shiftStage <= 8'h00;
         shiftBits  <= 4'h0;
         txActive   <= 1'h0;
         srFull     <= 1'h0;
      end else if (!isBuf || !(inTx || inRx)) begin
         shiftBits <= 4'h0;
         txActive  <= 1'h0; // [RL17]
         srFull    <= 1'h0;
      end else if (inTx) begin
         if (fifoRdPend) begin
            shiftStage <= hostRdData;
            shiftBits  <= 4'h8;
            txActive   <= 1'h1;
         end else if (bitTick && txActive) begin
            shiftStage <= {shiftStage[6:0], 1'b0}; // [RL24]
            shiftBits  <= shiftBits - 1'b1;
            if (shiftBits == 4'h1) begin
               txActive <= 1'h0; // [RL14]
            end
         end
      end else if (filling && bitTick) begin
         shiftStage <= {shiftStage[6:0], rxBit}; // [RL24]
         if (shiftBits == 4'h7) begin
            shiftBits <= 4'h0;
            srFull <= fifoFull;
         end else begin
            shiftBits <= shiftBits + 1'b1;
            srFull <= 1'h0;
         end
      end else begin
         srFull <= 1'h0;
      end
   end
   assign modData = isCont ? txData : shiftStage[7];

   // Receive fill control
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         filling <= 1'h0;
      end else if (!isBuf || !inRx || !fillEnable && ctrl.fillTriggerSelect != FILL_ON_SYNC) begin
         filling <= 1'h0; // [RL19]
      end else if (ctrl.fillTriggerSelect == FILL_ON_SYNC ? syncMatch : fillEnable) begin
         filling <= 1'h1; // [RL18]
      end
   end
   assign fifoWr     = isBuf && (inRx ? (filling && bitTick && shiftBits == 4'h7 && !fifoFull)
                                      : (selRise && hostWrite && !inRx)); // [RL21]
   assign fifoWrData = inRx ? {shiftStage[6:0], rxBit} : hostWrData;

   // Overrun flag, set wins over clear
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         overrun <= 1'h0;
      end else if (srFull || (isBuf && !inRx && selRise && hostWrite && fifoFull)) begin
         overrun <= 1'h1; // [RL22]
      end else if (overrunClear) begin
         overrun <= 1'h0; // [RL25]
      end
   end

   // Transmit finished
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         txDone <= 1'h0;
      end else if (!isBuf || !inTx || txActive || fifoRdPend) begin
         txDone <= 1'h0;
      end else begin
         txDone <= launched && fifoEmpty; // [RL16]
      end
   end

   byte_fifo #(.DEPTH(FIFO_DEPTH)) u_fifo (
      .mclk   (mclk),
      .resetn (resetn),
      .flush  (fifoFlush),
      .wrValid(fifoWr),
      .wrData (fifoWrData),
      .rdReq  (fifoRd),
      .rdData (hostRdData),
      .empty  (fifoEmpty),
      .full   (fifoFull)
   );

   // Pin outputs
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         dataOut <= 1'h0;
         dataOe <= 1'h0;
         bitClockOut <= 1'h0;
         event0 <= 1'h0;
      end else begin
         dataOe <= isCont && inRx; // [RL1]
         dataOut <= (isCont && inRx) ? rxBit : 1'h0; // [RL5] [RL6]
         if (isCont && inTx) begin
            bitClockOut <= bitPhase; // [RL2]
         end else if (isCont && inRx && bitSync) begin
            bitClockOut <= recClock; // [RL6]
         end else begin
            bitClockOut <= 1'h0; // [RL5] [RL9]
         end
         if (isCont && inRx) begin
            event0 <= (ctrl.event0Select == EVSRC_SYNC) ? syncMatch :
                      (ctrl.event0Select == EVSRC_RSSI) ? rssiEvent : 1'h0; // [RL8]
         end else begin
            event0 <= 1'h0; // [RL2] [RL9]
         end
      end
   end

   assign status.queueNotEmpty    = !fifoEmpty; // [RL15]
   assign status.queueFull        = fifoFull;
   assign status.queueOverrunFlag = overrun;
   assign status.transmitFinished = txDone;

   a_standby_quiet: assert property (@(posedge mclk) disable iff (!resetn) // [RL9]
      isCont && !inTx && !inRx |=> !event0 && !bitClockOut)
      else $error("event pin active in standby");
   a_cont_no_fifo: assert property (@(posedge mclk) disable iff (!resetn) // [RL1]
      isCont |-> !fifoWr && !fifoRd)
      else $error("fifo used in continuous mode");
   a_rawdata_noclk: assert property (@(posedge mclk) disable iff (!resetn) // [RL5]
      isCont && inRx && !ctrl.bitSyncEnable |=> !bitClockOut)
      else $error("bit clock without synchronizer");
   a_ev0_rssi: assert property (@(posedge mclk) disable iff (!resetn) // [RL8]
      isCont && inRx && ctrl.event0Select == EVSRC_RSSI |=> event0 == $past(rssiEvent))
      else $error("event0 not rssi");
   a_ev0_none: assert property (@(posedge mclk) disable iff (!resetn) // [RL8]
      isCont && inRx && ctrl.event0Select[1] |=> !event0)
      else $error("event0 driven for code 1x");
   a_overrun_set: assert property (@(posedge mclk) disable iff (!resetn) // [RL22]
      srFull |=> overrun)
      else $error("overrun not set");
   a_clear_flush: assert property (@(posedge mclk) disable iff (!resetn) // [RL25]
      overrunClear && !srFull |=> !overrun && fifoEmpty)
      else $error("clear did not empty");
   a_abort_tx: assert property (@(posedge mclk) disable iff (!resetn) // [RL17]
      txActive && !inTx |=> !txActive)
      else $error("transmit not stopped");
   a_done_idle: assert property (@(posedge mclk) disable iff (!resetn) // [RL16]
      txDone |-> !txActive && $past(fifoEmpty))
      else $error("finished while data remain");
   c_cont_tx: cover property (@(posedge mclk) disable iff (!resetn) isCont && inTx && bitTick);
   c_buf_done: cover property (@(posedge mclk) disable iff (!resetn) $rose(txDone));
   c_overrun: cover property (@(posedge mclk) disable iff (!resetn) $rose(overrun));
endmodule

// File: logic/radio_dp_pkg.sv
// Package: constants and carrier types for the radio data path
package radio_dp_pkg;
   localparam int          FIFO_DEPTH     = 64;
   localparam int          BIT_PERIOD_NS  = 5000;
   localparam int          CLK_PERIOD_NS  = 8;
   localparam int          BIT_CYCLES     = BIT_PERIOD_NS / CLK_PERIOD_NS;
   localparam int          BYTE_BITS      = 8;
   localparam logic [1:0]  EVSRC_SYNC     = 2'h0;
   localparam logic [1:0]  EVSRC_RSSI     = 2'h1;
   localparam logic        LAUNCH_NOTEMPTY = 1'h1;
   localparam logic        FILL_ON_SYNC   = 1'h0;

   typedef enum logic [1:0] {
      OP_STANDBY = 2'h0,
      OP_RX      = 2'h1,
      OP_TX      = 2'h3
   } opState_t;

   typedef enum logic [1:0] {
      MODE_CONTINUOUS = 2'h0,
      MODE_BUFFERED   = 2'h1
   } dataMode_t;

   typedef struct packed {
      dataMode_t  dataMode;
      opState_t   opState;
      logic       bitSyncEnable;
      logic       txLaunchCondition;
      logic       fillTriggerSelect;
      logic [1:0] event0Select;
   } ctrl_t;

   typedef struct packed {
      logic queueNotEmpty;
      logic queueFull;
      logic queueOverrunFlag;
      logic transmitFinished;
   } status_t;
endpackage

// File: test/host_pin_model.sv
// Host model: drives the data pin in step with the device bit clock
`timescale 1ns/100ps
module host_pin_model
   import radio_dp_pkg::*;
(
   // Clock and reset
   input  wire logic       mclk,
   input  wire logic       resetn,
   // Device pin side
   input  wire logic       bitClockOut,
   input  wire logic       dataOut,
   input  wire logic       dataOe,
   // Host side
   input  wire logic       hostDrive,
   input  wire logic [7:0] pattern,
   output      logic       dataIn,
   output      logic       hostBit
);
   logic       prevClk;
   logic [2:0] idx;

   // New bit only after a falling bit clock edge, far from the rising sample
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         prevClk <= 1'h0;
         idx     <= 3'h0;
         hostBit <= 1'h0;
      end else begin
         prevClk <= bitClockOut;
         if (prevClk && !bitClockOut) begin
            hostBit <= pattern[3'h7 - idx];
            idx     <= idx + 3'h1;
         end
      end
   end

   // Undriven pin rests at its pull-up level
   assign dataIn = dataOe ? dataOut : (hostDrive ? hostBit : 1'h1);
endmodule

// File: test/radio_continuous_buffered_datapath_bench.sv
// Self-checking testbench for the radio data path
`timescale 1ns/100ps
module radio_continuous_buffered_datapath_bench;
   import radio_dp_pkg::*;
   localparam int BC = 16;
   logic       mclk, resetn, fillEnable, overrunClear, queuePortSelectN, hostWrite;
   logic       dataIn, dataOut, dataOe, event0, bitClockOut, modData, hostDrive, hostBit;
   logic       demodRaw, demodClean, recClock, recRun, syncMatch, rssiEvent, prevBco;
   logic [7:0] hostWrData, hostRdData, pattern, got, rd;
   ctrl_t      ctrl;
   status_t    status;
   int         failCount, samplesChecked, cycles, n;
   integer     seed;
   logic [31:0] r;

   radio_datapath #(.BIT_CNT(BC)) dut (.mclk(mclk), .resetn(resetn), .ctrl(ctrl), .fillEnable(fillEnable),
      .overrunClear(overrunClear), .status(status), .queuePortSelectN(queuePortSelectN), .hostWrite(hostWrite),
      .hostWrData(hostWrData), .hostRdData(hostRdData), .dataIn(dataIn), .dataOut(dataOut), .dataOe(dataOe),
      .event0(event0), .bitClockOut(bitClockOut), .demodRaw(demodRaw), .demodClean(demodClean),
      .recClock(recClock), .syncMatch(syncMatch), .rssiEvent(rssiEvent), .modData(modData));

   host_pin_model host (.mclk(mclk), .resetn(resetn), .bitClockOut(bitClockOut), .dataOut(dataOut),
      .dataOe(dataOe), .hostDrive(hostDrive), .pattern(pattern), .dataIn(dataIn), .hostBit(hostBit));

   initial begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end

   // Link clock, toggling every 80 ns on a falling mclk edge
   always #80 if (recRun) recClock = ~recClock;

   always @(posedge mclk) begin
      prevBco <= bitClockOut;
      cycles++;
      if (cycles == 60000) begin
         failCount++;
         summarize();
      end
   end

   task automatic summarize;
      $display("comparisons %0d mismatches %0d", samplesChecked, failCount);
      if (failCount == 0 && samplesChecked > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      samplesChecked++;
      if (seen !== exp) begin
         failCount++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // One host byte frame; select goes high between frames; returns once a write has landed
   task automatic xfer(input logic wr, input logic [7:0] d, output logic [7:0] q);
      @(posedge mclk);
      queuePortSelectN <= 1'h0;
      hostWrite        <= wr;
      hostWrData       <= d;
      repeat (6) @(posedge mclk);
      q = hostRdData;
      queuePortSelectN <= 1'h1;
      repeat (4) @(posedge mclk);
   endtask

   task automatic waitBit(input int idx, input logic v, input int lim);
      n = 0;
      while (status[idx] !== v && n < lim) begin
         @(posedge mclk);
         n++;
      end
      check(status[idx], v);
   endtask

   task automatic setCtrl(input ctrl_t c);
      @(posedge mclk);
      ctrl <= c;
      repeat (4) @(posedge mclk);
   endtask

   initial begin
      seed = 32'h3EF9;
      resetn = 1'h0;
      ctrl = '0;
      {fillEnable, overrunClear, hostWrite, demodRaw, demodClean, recClock, recRun} = '0;
      {syncMatch, rssiEvent, hostDrive} = '0;
      queuePortSelectN = 1'h1;
      hostWrData = 8'h00;
      pattern = 8'h00;
      repeat (16) @(posedge mclk);
      resetn <= 1'h1;
      repeat (3) @(posedge mclk);
      // Continuous standby with every event source active
      {syncMatch, rssiEvent, recClock} <= 3'h7;
      setCtrl('{MODE_CONTINUOUS, OP_STANDBY, 1'h1, 1'h1, 1'h0, EVSRC_SYNC});
      check(event0, 1'h0);
      check(bitClockOut, 1'h0);
      // Continuous receive, all event0 codes, sync on and off
      for (int i = 0; i < 8; i++) begin
         r = $random(seed);
         setCtrl('{MODE_CONTINUOUS, OP_RX, r[0], 1'h1, 1'h0, i[1:0]});
         {demodRaw, demodClean, recClock, syncMatch, rssiEvent} <= r[7:3];
         repeat (4) @(posedge mclk);
         check(dataOut, r[0] ? r[6] : r[7]);
         check(bitClockOut, r[0] & r[5]);
         check(event0, i[1] ? 1'h0 : (i[0] ? r[3] : r[4]));
         check(dataOe, 1'h1);
      end
      // Continuous transmit: host bits sampled on the bit clock
      pattern <= 8'($random(seed));
      hostDrive <= 1'h1;
      setCtrl('{MODE_CONTINUOUS, OP_TX, 1'h1, 1'h1, 1'h0, EVSRC_SYNC});
      // Let the pin and the first bit after the mode change settle
      repeat (2 * BC) @(posedge mclk);
      for (int b = 0; b < 16; b++) begin
         n = 0;
         do begin
            @(posedge mclk);
            n++;
         end while (!(prevBco === 1'b1 && bitClockOut === 1'b0) && n < 4 * BC);
         check(n < 4 * BC, 1'h1);
         check(modData, hostBit);
         check(event0, 1'h0);
      end
      // Buffered transmit of single bytes, launched on first byte
      hostDrive <= 1'h0;
      setCtrl('{MODE_BUFFERED, OP_TX, 1'h0, LAUNCH_NOTEMPTY, 1'h0, EVSRC_SYNC});
      for (int i = 0; i < 3; i++) begin
         pattern = 8'($random(seed));
         xfer(1'h1, pattern, rd);
         waitBit(3, 1'h1, 10);
         waitBit(3, 1'h0, 10);
         for (int k = 0; k < 8; k++) begin
            repeat (k == 0 ? BC / 2 : BC) @(posedge mclk);
            got[7 - k] = modData;
         end
         check(got, pattern);
         waitBit(0, 1'h1, 3 * BC);
      end
      // Launch only once full, then leave transmit mid-byte
      setCtrl('{MODE_BUFFERED, OP_STANDBY, 1'h0, 1'h0, 1'h0, EVSRC_SYNC});
      setCtrl('{MODE_BUFFERED, OP_TX, 1'h0, 1'h0, 1'h0, EVSRC_SYNC});
      for (int i = 0; i < FIFO_DEPTH; i++) xfer(1'h1, 8'($random(seed)), rd);
      check(status.queueFull, 1'h1);
      waitBit(2, 1'h0, 4);
      setCtrl('{MODE_BUFFERED, OP_STANDBY, 1'h0, 1'h0, 1'h0, EVSRC_SYNC});
      repeat (2 * BC) @(posedge mclk);
      check(status.transmitFinished, 1'h0);
      overrunClear <= 1'h1;
      @(posedge mclk);
      overrunClear <= 1'h0;
      waitBit(3, 1'h0, 4);
      // Standby: fill to full, one more byte overruns, clear flushes
      setCtrl('{MODE_BUFFERED, OP_STANDBY, 1'h0, 1'h0, 1'h0, EVSRC_SYNC});
      for (int i = 0; i < FIFO_DEPTH; i++) xfer(1'h1, 8'($random(seed)), rd);
      check(status.queueFull, 1'h1);
      xfer(1'h1, 8'hA5, rd);
      waitBit(1, 1'h1, 4);
      overrunClear <= 1'h1;
      @(posedge mclk);
      overrunClear <= 1'h0;
      waitBit(1, 1'h0, 4);
      waitBit(3, 1'h0, 4);
      // Buffered receive filled on demand, then left unread
      {demodClean, demodRaw, fillEnable, recRun} <= 4'hF;
      setCtrl('{MODE_BUFFERED, OP_RX, 1'h0, 1'h0, 1'h1, EVSRC_SYNC});
      waitBit(3, 1'h1, 400);
      xfer(1'h0, 8'h00, rd);
      check(rd, 8'hFF);
      waitBit(2, 1'h1, 15000);
      repeat (90) @(posedge mclk);
      check(status.queueOverrunFlag, 1'h0);
      waitBit(1, 1'h1, 200);
      xfer(1'h0, 8'h00, rd);
      check(rd, 8'hFF);
      // Sync-triggered fill stores nothing before a match
      {fillEnable, syncMatch} <= 2'h0;
      overrunClear <= 1'h1;
      setCtrl('{MODE_BUFFERED, OP_STANDBY, 1'h0, 1'h0, 1'h0, EVSRC_SYNC});
      overrunClear <= 1'h0;
      setCtrl('{MODE_BUFFERED, OP_RX, 1'h0, 1'h0, FILL_ON_SYNC, EVSRC_SYNC});
      repeat (400) @(posedge mclk);
      check(status.queueNotEmpty, 1'h0);
      syncMatch <= 1'h1;
      @(posedge mclk);
      syncMatch <= 1'h0;
      waitBit(3, 1'h1, 400);
      summarize();
   end
endmodule
